// ---- hdl/fbom_defs.svh ----
// timing counts and pin level codes for the flash bus host controller
// assumes a 100 MHz clk_in; times are in ns and counts derive from them
`ifndef FBOM_DEFS_SVH
`define FBOM_DEFS_SVH
`define FBOM_CLK_PERIOD_NS   10
`define FBOM_T_ACC_NS        85
`define FBOM_T_WP_NS         35
`define FBOM_T_RP_NS         500
`define FBOM_T_RH_NS         50
`define FBOM_ACC_CYC  ((`FBOM_T_ACC_NS + `FBOM_CLK_PERIOD_NS - 1) / `FBOM_CLK_PERIOD_NS)
`define FBOM_WP_CYC   ((`FBOM_T_WP_NS + `FBOM_CLK_PERIOD_NS - 1) / `FBOM_CLK_PERIOD_NS)
`define FBOM_RP_CYC   ((`FBOM_T_RP_NS + `FBOM_CLK_PERIOD_NS - 1) / `FBOM_CLK_PERIOD_NS)
`define FBOM_RH_CYC   ((`FBOM_T_RH_NS + `FBOM_CLK_PERIOD_NS - 1) / `FBOM_CLK_PERIOD_NS)
`define FBOM_CNT_W           8
`define FBOM_ACCEL_OFF       2'h0
`define FBOM_ACCEL_HIGH      2'h1
`define FBOM_ACCEL_VHH       2'h2
`endif

// ---- hdl/fbom_host.sv ----
// host-side controller that drives the flash pins for reads, writes and reset
// assumes the flash pins are sampled through three flops and one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "fbom_defs.svh"

module fbom_host #(
  parameter int ACC_CYC = `FBOM_ACC_CYC,
  parameter int WP_CYC  = `FBOM_WP_CYC,
  parameter int RP_CYC  = `FBOM_RP_CYC,
  parameter int RH_CYC  = `FBOM_RH_CYC
) (
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  input  wire logic               req_valid_in,
  output logic                    req_ready_out,
  input  wire fbom_pkg::fbom_req_t req_in,
  input  wire logic               width_select_in,
  input  wire logic [1:0]         accel_mode_in,
  output logic                    rsp_valid_out,
  output logic [15:0]             rsp_data_out,
  output fbom_pkg::fbom_ctl_t     ctl_out,
  output logic [19:0]             addr_out,
  output logic                    width_select_out,
  output logic [1:0]              protect_accel_pin_out,
  output logic [15:0]             dq_out,
  output logic [15:0]             dq_oe_out,
  input  wire logic [15:0]        dq_in
);
  typedef enum logic [2:0] {S_IDLE, S_READ, S_WRITE, S_RECOVER, S_RESET} fbom_state_t;

  fbom_state_t               state_reg, state_next;
  logic [`FBOM_CNT_W-1:0]    cnt_reg;
  logic [15:0]               dq_s1_reg, dq_s2_reg, dq_s3_reg, dq_stable_reg;
  fbom_pkg::fbom_req_t       req_reg;
  logic                      width_reg;
  logic [1:0]                accel_reg;
  logic                      rsp_valid_reg;
  logic [15:0]               rsp_data_reg;
  // cycles spent in the present state; the timing assertions count with it
  // so that they do not lean on the phase counter they are meant to check
  logic [`FBOM_CNT_W-1:0]    age_reg;

  // ==========================================================
  // decode
  wire take_req   = req_valid_in && (state_reg == S_IDLE);
  wire cnt_done   = (cnt_reg == '0);
  wire in_read    = (state_reg == S_READ);
  wire in_write   = (state_reg == S_WRITE);
  wire in_reset   = (state_reg == S_RESET);
  wire is_byte    = !width_reg;
  // the vhh code may be driven only while the latched request is a write (program)
  wire accel_ok   = (accel_reg != `FBOM_ACCEL_VHH) ||
                    (req_reg.op == fbom_pkg::FBOM_OP_WRITE);
  wire [15:0] rd_word = is_byte ? {8'h00, dq_stable_reg[7:0]} : dq_stable_reg;
  wire [`FBOM_CNT_W-1:0] load_cnt =
    (req_in.op == fbom_pkg::FBOM_OP_READ)  ? `FBOM_CNT_W'(ACC_CYC + 3) :
    (req_in.op == fbom_pkg::FBOM_OP_WRITE) ? `FBOM_CNT_W'(WP_CYC) :
                                             `FBOM_CNT_W'(RP_CYC);

  assign req_ready_out         = (state_reg == S_IDLE);
  assign rsp_valid_out         = rsp_valid_reg;
  assign rsp_data_out          = rsp_data_reg;
  assign width_select_out      = width_reg;
  assign protect_accel_pin_out = accel_ok ? accel_reg : `FBOM_ACCEL_HIGH;
  assign addr_out              = req_reg.addr;
  // flash select only while sram selects are idle; sram held deselected
  assign ctl_out.flash_sel_n       = !(in_read || in_write);
  assign ctl_out.out_gate_n        = !in_read;
  assign ctl_out.wr_strobe_n       = !in_write;
  assign ctl_out.reset_n           = !in_reset;
  assign ctl_out.sram_select_low_n = 1'b1;
  assign ctl_out.sram_select_high  = 1'b0;
  assign dq_out    = is_byte ? {req_reg.byte_lsb, 7'h00, req_reg.data[7:0]} : req_reg.data;
  // in byte mode line fifteen carries the low address bit on reads and writes
  assign dq_oe_out = in_write ? (is_byte ? 16'h80FF : 16'hFFFF) :
                     (in_read && is_byte) ? 16'h8000 : 16'h0000;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:    if (req_valid_in) state_next = (req_in.op == fbom_pkg::FBOM_OP_READ) ? S_READ :
                   (req_in.op == fbom_pkg::FBOM_OP_WRITE) ? S_WRITE : S_RESET;
      S_READ:    if (cnt_done) state_next = S_RECOVER;
      S_WRITE:   if (cnt_done) state_next = S_RECOVER;
      S_RESET:   if (cnt_done) state_next = S_RECOVER;
      S_RECOVER: if (cnt_done) state_next = S_IDLE;
      default:   state_next = S_IDLE;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg <= S_IDLE;
      cnt_reg   <= '0;
      req_reg   <= '0;
      width_reg <= 1'b1;
      accel_reg <= `FBOM_ACCEL_OFF;
      age_reg   <= '0;
    end
    else
    begin
      state_reg <= state_next;
      age_reg   <= (state_next != state_reg) ? '0 : age_reg + 1'b1;
      if (take_req)
      begin
        cnt_reg   <= load_cnt;
        req_reg   <= req_in;
        width_reg <= width_select_in;
        accel_reg <= accel_mode_in;
      end
      else if (!cnt_done)
        cnt_reg <= cnt_reg - 1'b1;
      else if (state_next == S_RECOVER)
        cnt_reg <= `FBOM_CNT_W'(RH_CYC);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      dq_s1_reg     <= '0;
      dq_s2_reg     <= '0;
      dq_s3_reg     <= '0;
      dq_stable_reg <= '0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= '0;
    end
    else
    begin
      dq_s1_reg <= dq_in;
      dq_s2_reg <= dq_s1_reg;
      dq_s3_reg <= dq_s2_reg;
      if (dq_s2_reg == dq_s3_reg)
        dq_stable_reg <= dq_s3_reg;
      rsp_valid_reg <= in_read && cnt_done;
      if (in_read && cnt_done)
        rsp_data_reg <= rd_word;
    end
  end

  // ==========================================================
  // assertions
  a_read_pins: assert property (@(posedge clk_in) disable iff (rst_in)
    in_read |-> !ctl_out.flash_sel_n && !ctl_out.out_gate_n && ctl_out.wr_strobe_n)
    else $error("read cycle pins wrong");
  a_write_pins: assert property (@(posedge clk_in) disable iff (rst_in)
    in_write |-> !ctl_out.flash_sel_n && ctl_out.out_gate_n && !ctl_out.wr_strobe_n)
    else $error("write cycle pins wrong");
  a_no_contend: assert property (@(posedge clk_in) disable iff (rst_in)
    !(!ctl_out.flash_sel_n && !ctl_out.sram_select_low_n && ctl_out.sram_select_high))
    else $error("flash and sram selected together");
  a_read_wait: assert property (@(posedge clk_in) disable iff (rst_in)
    (in_read && cnt_done) |-> int'(age_reg) >= ACC_CYC)
    else $error("read sampled before access time");
  a_rsp_after: assert property (@(posedge clk_in) disable iff (rst_in)
    (in_read && cnt_done) |=> rsp_valid_out && !in_read)
    else $error("read response missing");
  a_byte_oe: assert property (@(posedge clk_in) disable iff (rst_in)
    (in_write && is_byte) |-> dq_oe_out[14:8] == 7'h00)
    else $error("byte mode drives upper lines");
  a_word_oe: assert property (@(posedge clk_in) disable iff (rst_in)
    (in_write && !is_byte) |-> dq_oe_out == 16'hFFFF)
    else $error("word mode write not full width");
  a_vhh_gate: assert property (@(posedge clk_in) disable iff (rst_in)
    (protect_accel_pin_out == `FBOM_ACCEL_VHH) |-> req_reg.op == fbom_pkg::FBOM_OP_WRITE)
    else $error("accel voltage outside programming");
  a_reset_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    (in_reset && cnt_done) |-> !ctl_out.reset_n && int'(age_reg) >= RP_CYC)
    else $error("reset pulse too short");
  a_gate_float: assert property (@(posedge clk_in) disable iff (rst_in)
    ctl_out.out_gate_n && !in_write |-> dq_oe_out[7:0] == 8'h00)
    else $error("host drives data while idle");
  a_byte_read: assert property (@(posedge clk_in) disable iff (rst_in)
    (in_read && is_byte) |-> dq_oe_out == 16'h8000 && dq_out[15] == req_reg.byte_lsb)
    else $error("byte read address line wrong");
  a_idle_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == S_IDLE) |-> ctl_out.flash_sel_n && dq_oe_out == 16'h0000)
    else $error("host active while idle");
  a_vhh_write: assert property (@(posedge clk_in) disable iff (rst_in)
    (in_write && accel_reg == `FBOM_ACCEL_VHH) |-> protect_accel_pin_out == `FBOM_ACCEL_VHH)
    else $error("accel voltage missing in program");
  a_write_data: assert property (@(posedge clk_in) disable iff (rst_in)
    (in_write && !is_byte) |-> dq_out == req_reg.data)
    else $error("word program data wrong");

  c_read:  cover property (@(posedge clk_in) disable iff (rst_in) rsp_valid_out);
  c_write: cover property (@(posedge clk_in) disable iff (rst_in) $fell(in_write));
  c_reset: cover property (@(posedge clk_in) disable iff (rst_in) $fell(in_reset));
  c_byte:  cover property (@(posedge clk_in) disable iff (rst_in) in_read && is_byte);
  c_accel: cover property (@(posedge clk_in) disable iff (rst_in)
    in_write && protect_accel_pin_out == `FBOM_ACCEL_VHH);
endmodule : fbom_host
`default_nettype wire

// ---- hdl/fbom_pkg.sv ----
// types shared by the flash bus host controller
// assumes nothing beyond the defs header for constants
package fbom_pkg;
  typedef enum logic [1:0] {FBOM_OP_READ, FBOM_OP_WRITE, FBOM_OP_RESET} fbom_op_t;

  typedef struct packed {
    fbom_op_t    op;
    logic [19:0] addr;
    logic        byte_lsb;
    logic [15:0] data;
  } fbom_req_t;

  typedef struct packed {
    logic        flash_sel_n;
    logic        out_gate_n;
    logic        wr_strobe_n;
    logic        reset_n;
    logic        sram_select_low_n;
    logic        sram_select_high;
  } fbom_ctl_t;
endpackage : fbom_pkg

// ---- verif/fbom_flash_model.sv ----
// behavioural flash die that answers the host controller pins
// assumes the bus is resolved here: host drive wins, then die drive, else float
`timescale 1ns/1ps
`default_nettype none
`include "fbom_defs.svh"
module fbom_flash_model (
  input  wire fbom_pkg::fbom_ctl_t ctl_in,
  input  wire logic [19:0]         addr_in,
  input  wire logic                width_select_in,
  input  wire logic [15:0]         dq_host_in,
  input  wire logic [15:0]         dq_host_oe_in,
  input  wire logic [1:0]          protect_pin_in,
  output logic [15:0]              dq_bus_out
);
  // ==========
  // array and read path
  logic [15:0] mem [256];
  logic [15:0] word_q;
  logic [15:0] rd_val;
  logic [15:0] drv_en;
  logic        rd_on;
  logic        lsb;
  logic        boot_locked;
  initial for (int i = 0; i < 256; i++) mem[i] = 16'hC300 | 16'(i);
  assign lsb    = dq_host_in[15];
  // the bottom boot sector region (addr_in[19:13] zero) refuses writes while the protect pin is low
  assign boot_locked = (protect_pin_in == `FBOM_ACCEL_OFF) && (addr_in[19:13] == 7'h00);
  assign word_q = mem[addr_in[7:0]];
  assign rd_val = width_select_in ? word_q : {8'h00, lsb ? word_q[15:8] : word_q[7:0]};
  assign rd_on  = !ctl_in.flash_sel_n && !ctl_in.out_gate_n && ctl_in.reset_n;
  assign drv_en = !rd_on ? 16'h0000 : width_select_in ? 16'hFFFF : 16'h00FF;
  // a floating line shows the inverse so stale data never passes for a read
  always_comb
    for (int b = 0; b < 16; b++)
      dq_bus_out[b] = dq_host_oe_in[b] ? dq_host_in[b] : drv_en[b] ? rd_val[b] : ~rd_val[b];
  // ==========
  // write path, sampled once the strobe phase has settled
  always @(negedge ctl_in.wr_strobe_n)
  begin
    #1;
    // a write is committed at the strobe, so a later deselect cannot cut it
    if (!ctl_in.flash_sel_n && ctl_in.out_gate_n && ctl_in.reset_n && !boot_locked)
      if (width_select_in) mem[addr_in[7:0]] = dq_host_in;
      else if (lsb) mem[addr_in[7:0]][15:8] = dq_host_in[7:0];
      else mem[addr_in[7:0]][7:0] = dq_host_in[7:0];
  end
endmodule : fbom_flash_model
`default_nettype wire

// ---- verif/test_flash_bus_operation_modes.sv ----
// self-checking bench for the flash bus host controller and its die model
// assumes short timing parameters so each phase lasts a few cycles
`timescale 1ns/1ps
`default_nettype none
`include "fbom_defs.svh"
module test_flash_bus_operation_modes;
  // ==========
  // clock, reset and design
  logic clk_in = 1'b0, rst_in = 1'b1, req_valid_in = 1'b0, width_select_in = 1'b1;
  logic [1:0] accel_mode_in = 2'h0, wr_acc = 2'h0, rd_acc = 2'h0, protect_accel_pin_out;
  fbom_pkg::fbom_req_t req_in = '0;
  fbom_pkg::fbom_ctl_t ctl_out;
  logic req_ready_out, rsp_valid_out, width_select_out;
  logic [15:0] rsp_data_out, dq_out, dq_oe_out, dq_bus, rd = 16'h0000, wr_oe = 16'h0000;
  logic [19:0] addr_out;
  logic got_rsp = 1'b0, wr_gate = 1'b0, rd_we = 1'b0, rst_seen = 1'b0;
  logic strobe_q = 1'b1;
  int n_strobe = 0;
  int error_cnt = 0;
  int n_compared = 0;
  initial forever #5 clk_in = ~clk_in;
  fbom_host #(.ACC_CYC(2), .WP_CYC(2), .RP_CYC(4), .RH_CYC(2)) u_fbom_host (
    .clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
    .req_ready_out(req_ready_out), .req_in(req_in), .width_select_in(width_select_in),
    .accel_mode_in(accel_mode_in), .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
    .ctl_out(ctl_out), .addr_out(addr_out), .width_select_out(width_select_out),
    .protect_accel_pin_out(protect_accel_pin_out), .dq_out(dq_out), .dq_oe_out(dq_oe_out),
    .dq_in(dq_bus));
  fbom_flash_model u_fbom_flash_model (.ctl_in(ctl_out), .addr_in(addr_out),
    .width_select_in(width_select_out), .dq_host_in(dq_out), .dq_host_oe_in(dq_oe_out),
    .protect_pin_in(protect_accel_pin_out), .dq_bus_out(dq_bus));
  // ==========
  // pin monitor
  always @(posedge clk_in)
  begin
    if (!ctl_out.wr_strobe_n)
      {wr_oe, wr_gate, wr_acc} <= {dq_oe_out, ctl_out.out_gate_n, protect_accel_pin_out};
    strobe_q <= ctl_out.wr_strobe_n;
    if (strobe_q && !ctl_out.wr_strobe_n) n_strobe <= n_strobe + 1;
    if (!ctl_out.out_gate_n) {rd_we, rd_acc} <= {ctl_out.wr_strobe_n, protect_accel_pin_out};
    if (!ctl_out.reset_n) rst_seen <= 1'b1;
  end
  // ==========
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic issue(input fbom_pkg::fbom_op_t op, input logic [19:0] a, input logic lsb,
      input logic [15:0] d, input logic w, input logic [1:0] acc);
    int n;
    @(negedge clk_in);
    req_in = '{op, a, lsb, d};
    {req_valid_in, width_select_in, accel_mode_in, got_rsp} = {1'b1, w, acc, 1'b0};
    n = 0;
    @(posedge clk_in);
    while (req_ready_out !== 1'b1 && n < 50)
    begin
      n = n + 1;
      @(posedge clk_in);
    end
    @(negedge clk_in);
    req_valid_in = 1'b0;
    n = 0;
    while (req_ready_out !== 1'b1 && n < 200)
    begin
      n = n + 1;
      @(posedge clk_in);
      if (rsp_valid_out === 1'b1) {got_rsp, rd} = {1'b1, rsp_data_out};
    end
    // a hung phase or a read with no answer counts as a mismatch
    if (req_ready_out !== 1'b1 || (op == fbom_pkg::FBOM_OP_READ && got_rsp !== 1'b1))
    begin
      error_cnt++;
      $display("BAD %0t request %0d not finished", $time, op);
    end
  endtask : issue
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // ==========
  // scenarios
  task automatic t_word();
    issue(fbom_pkg::FBOM_OP_READ, 20'h00005, 1'b0, 16'h0000, 1'b1, `FBOM_ACCEL_HIGH);
    chk(rd, 16'hC305, "boot read");
    chk({got_rsp, rd_we}, 2'b11, "read pins");
    issue(fbom_pkg::FBOM_OP_WRITE, 20'h00012, 1'b0, 16'hBEEF, 1'b1, `FBOM_ACCEL_HIGH);
    chk(wr_oe, 16'hFFFF, "word drive");
    chk({15'h0, wr_gate}, 16'h0001, "gate in write");
    issue(fbom_pkg::FBOM_OP_READ, 20'h00012, 1'b0, 16'h0000, 1'b1, `FBOM_ACCEL_HIGH);
    chk(rd, 16'hBEEF, "word readback");
    $display("test word done");
  endtask : t_word
  task automatic t_byte();
    issue(fbom_pkg::FBOM_OP_WRITE, 20'h00021, 1'b1, 16'h005A, 1'b0, `FBOM_ACCEL_HIGH);
    chk(wr_oe, 16'h80FF, "byte drive");
    issue(fbom_pkg::FBOM_OP_READ, 20'h00021, 1'b1, 16'h0000, 1'b0, `FBOM_ACCEL_HIGH);
    chk(rd, 16'h005A, "upper byte");
    issue(fbom_pkg::FBOM_OP_READ, 20'h00021, 1'b0, 16'h0000, 1'b0, `FBOM_ACCEL_HIGH);
    chk(rd, 16'h0021, "lower byte");
    $display("test byte done");
  endtask : t_byte
  task automatic t_accel_reset();
    int s0;
    s0 = n_strobe;
    issue(fbom_pkg::FBOM_OP_WRITE, 20'h00555, 1'b0, 16'h00A0, 1'b1, `FBOM_ACCEL_VHH);
    issue(fbom_pkg::FBOM_OP_WRITE, 20'h00030, 1'b0, 16'h1234, 1'b1, `FBOM_ACCEL_VHH);
    chk(16'(n_strobe - s0), 16'h0002, "bypass cycles");
    chk({14'h0, wr_acc}, 16'h0002, "accel in write");
    issue(fbom_pkg::FBOM_OP_READ, 20'h00030, 1'b0, 16'h0000, 1'b1, `FBOM_ACCEL_VHH);
    chk({14'h0, rd_acc}, 16'h0001, "no accel in read");
    chk(rd, 16'h1234, "accel readback");
    issue(fbom_pkg::FBOM_OP_RESET, 20'h00000, 1'b0, 16'h0000, 1'b1, `FBOM_ACCEL_HIGH);
    chk({15'h0, rst_seen}, 16'h0001, "reset pulse");
    issue(fbom_pkg::FBOM_OP_READ, 20'h00012, 1'b0, 16'h0000, 1'b1, `FBOM_ACCEL_HIGH);
    chk(rd, 16'hBEEF, "read after reset");
    chk(ctl_out, 16'h003E, "idle pins");
    $display("test accel reset done");
  endtask : t_accel_reset
  task automatic t_protect();
    issue(fbom_pkg::FBOM_OP_WRITE, 20'h00040, 1'b0, 16'h7777, 1'b1, `FBOM_ACCEL_OFF);
    issue(fbom_pkg::FBOM_OP_READ, 20'h00040, 1'b0, 16'h0000, 1'b1, `FBOM_ACCEL_OFF);
    chk(rd, 16'hC340, "boot sector locked");
    issue(fbom_pkg::FBOM_OP_WRITE, 20'h02040, 1'b0, 16'h7777, 1'b1, `FBOM_ACCEL_OFF);
    issue(fbom_pkg::FBOM_OP_READ, 20'h02040, 1'b0, 16'h0000, 1'b1, `FBOM_ACCEL_OFF);
    chk(rd, 16'h7777, "inner sector open");
    $display("test protect done");
  endtask : t_protect
  initial
  begin
    repeat (20) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    t_word();
    t_byte();
    t_accel_reset();
    t_protect();
    give_verdict();
  end
  initial
  begin
    #30000;
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    give_verdict();
  end
endmodule : test_flash_bus_operation_modes
`default_nettype wire
